// ==== rtl/pcie_map.svh ====
`ifndef PCIE_MAP_SVH
`define PCIE_MAP_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PCIE_SKT_EVENT      8'h00
`define PCIE_SKT_MASK       8'h04
`define PCIE_SKT_PRESENT    8'h08
`define PCIE_SKT_FORCE      8'h0c
`define PCIE_SKT_CONTROL    8'h10
`define PCIE_SKT_PWR_MGMT   8'h20
`define PCIE_SKT_RSV        8'h14
`define PCIE_LEG_FLAGS      8'h40
`define PCIE_LEG_MASK       8'h44
`define PCIE_LEG_GLOBAL     8'h48
`define PCIE_FUNC_STATUS    8'h4c
`define PCIE_ROUTE          8'h50
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCIE_BIT_CSTS       0
`define PCIE_BIT_CD_A       1
`define PCIE_BIT_CD_B       2
`define PCIE_BIT_PWR        3
`define PCIE_BIT_BVD1       1
`define PCIE_BIT_BVD2       0
`define PCIE_BIT_READY      2
`define PCIE_BIT_STSCHG     0
`define PCIE_BIT_CLR_W1C    2
`define PCIE_BIT_FUNC       0
// ----------------------------------------
// Reset values, card kinds and response codes
// ----------------------------------------
`define PCIE_MASK_RST       4'hf
`define PCIE_GLOBAL_RST     8'h00
`define PCIE_ROUTE_RST      8'h00
`define PCIE_CARD_MEM       2'h0
`define PCIE_CARD_IO        2'h1
`define PCIE_CARD_CB        2'h2
`define PCIE_RESP_OKAY      2'h0
`define PCIE_RESP_SLVERR    2'h2
`endif

// ==== rtl/pcie_pkg.sv ====
package pcie_pkg;
   typedef enum logic [1:0] {
      PCIE_CARD_MEM16 = 2'h0,
      PCIE_CARD_IO16  = 2'h1,
      PCIE_CARD_CBUS  = 2'h2,
      PCIE_CARD_NONE  = 2'h3
   } pcie_card_t;

   typedef struct packed {
      logic       cd1;
      logic       cd2;
      logic       bvd1;
      logic       bvd2;
      logic       ready;
      logic       irq;
      logic       pwr_done;
      pcie_card_t kind;
   } pcie_card_pins_t;

   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } pcie_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } pcie_axi_rsp_t;

   typedef struct packed {
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic [5:0] prev;
      logic       pwr1;
      logic       pwr2;
      logic       pwr_prev;
      logic [3:0] sk_flag;
      logic [3:0] sk_mask;
      logic [3:0] lg_flag;
      logic [3:0] lg_mask;
      logic [7:0] glob;
      logic [31:0] ctrl;
      logic [31:0] pm;
      logic [7:0] route;
      logic       func;
      logic       aw_got;
      logic       w_got;
      logic [7:0] awa;
      logic [31:0] wd;
      logic [3:0] ws;
      pcie_axi_rsp_t rsp;
      logic [7:0] irq_pins;
      logic       pci_int_n;
      logic       ser_irq;
   } pcie_state_t;
endpackage

// ==== rtl/pcie_events.sv ====
// Chosen here: the AXI4-Lite slave port.
`include "pcie_map.svh"
module pcie_events (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  pcie_pkg::pcie_card_pins_t    card,
   input  pcie_pkg::pcie_axi_req_t      axi_req,
   output pcie_pkg::pcie_axi_rsp_t      axi_rsp,
   output logic [7:0]                   legacy_irq_route_pin,
   output logic                         pci_int_n,
   output logic                         serialized_irq_line
);
   import pcie_pkg::*;

   pcie_state_t s_r;
   pcie_state_t s_nxt;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] one_hot8(input logic [2:0] sel, input logic en);
      one_hot8 = en ? (8'h01 << sel) : 8'h00;
   endfunction

   logic [5:0] pin_vec;
   logic [5:0] edg;
   logic       is_mem;
   logic       is_io;
   logic       is_cb;
   logic [3:0] sk_set;
   logic [3:0] lg_set;
   logic       pwr_evt;
   logic       wr_go;
   logic       rd_go;
   logic [7:0] rd_a;
   logic [31:0] rd_d;
   logic       rd_hit;
   logic       wr_hit;
   logic [3:0] sk_clr;
   logic [3:0] lg_clr;
   logic       csc_req;
   logic       func_req;
   logic [7:0] csc_pins;
   logic [7:0] func_pins;

   assign pin_vec = {card.cd1, card.cd2, card.bvd1, card.bvd2, card.ready, card.irq};

   always_comb begin
      s_nxt = s_r;
      // ----------------------------------------
      // Synchronise card pins, find edges
      // ----------------------------------------
      s_nxt.sync1 = pin_vec;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.prev  = s_r.sync2;
      s_nxt.pwr1  = card.pwr_done;
      s_nxt.pwr2  = s_r.pwr1;
      s_nxt.pwr_prev = s_r.pwr2;
      edg     = s_r.sync2 ^ s_r.prev;
      pwr_evt = s_r.pwr2 & ~s_r.pwr_prev;
      is_mem  = (card.kind == PCIE_CARD_MEM16);
      is_io   = (card.kind == PCIE_CARD_IO16);
      is_cb   = (card.kind == PCIE_CARD_CBUS);

      sk_set = 4'h0;
      lg_set = 4'h0;
      sk_set[`PCIE_BIT_CD_A] = edg[5];
      sk_set[`PCIE_BIT_CD_B] = edg[4];
      sk_set[`PCIE_BIT_CSTS] = is_cb & s_r.sync2[3] & ~s_r.prev[3];
      sk_set[`PCIE_BIT_PWR]  = is_cb & pwr_evt;
      lg_set[`PCIE_BIT_BVD1] = is_mem & edg[3];
      lg_set[`PCIE_BIT_BVD2] = is_mem & edg[2];
      lg_set[`PCIE_BIT_READY] = is_mem & edg[1];
      if (is_io && s_r.sync2[3] && !s_r.prev[3]) begin
         lg_set[`PCIE_BIT_STSCHG] = 1'b1;
      end
      lg_set[`PCIE_BIT_PWR] = (is_mem | is_io) & pwr_evt;
      s_nxt.func = (is_io | is_cb) & s_r.sync2[0];

      // ----------------------------------------
      // AXI4-Lite slave
      // ----------------------------------------
      s_nxt.rsp.awready = 1'b0;
      s_nxt.rsp.wready  = 1'b0;
      s_nxt.rsp.arready = 1'b0;
      if (axi_req.awvalid && !s_r.aw_got && !s_r.rsp.bvalid && !s_r.rsp.awready) begin
         s_nxt.rsp.awready = 1'b1;
      end
      if (axi_req.wvalid && !s_r.w_got && !s_r.rsp.bvalid && !s_r.rsp.wready) begin
         s_nxt.rsp.wready = 1'b1;
      end
      if (s_r.rsp.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awa    = axi_req.awaddr[7:0];
      end
      if (s_r.rsp.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wd    = axi_req.wdata;
         s_nxt.ws    = axi_req.wstrb;
      end
      wr_go  = s_r.aw_got & s_r.w_got & ~s_r.rsp.bvalid;
      sk_clr = 4'h0;
      lg_clr = 4'h0;
      wr_hit = 1'b1;
      if (wr_go) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.rsp.bvalid = 1'b1;
         unique case (s_r.awa)
            `PCIE_SKT_EVENT: sk_clr = s_r.wd[3:0] & {4{s_r.ws[0]}};
            `PCIE_SKT_MASK: if (s_r.ws[0]) s_nxt.sk_mask = s_r.wd[3:0];
            `PCIE_SKT_FORCE: sk_set = sk_set | (s_r.wd[3:0] & {4{s_r.ws[0]}});
            `PCIE_SKT_CONTROL: s_nxt.ctrl = apply_strb(s_r.ctrl, s_r.wd, s_r.ws);
            `PCIE_SKT_PWR_MGMT: s_nxt.pm = apply_strb(s_r.pm, s_r.wd, s_r.ws);
            `PCIE_LEG_FLAGS: begin
               if (s_r.glob[`PCIE_BIT_CLR_W1C] && s_r.ws[0]) begin
                  lg_clr = s_r.wd[3:0];
               end
            end
            `PCIE_LEG_MASK: if (s_r.ws[0]) s_nxt.lg_mask = s_r.wd[3:0];
            `PCIE_LEG_GLOBAL: if (s_r.ws[0]) s_nxt.glob = s_r.wd[7:0];
            `PCIE_ROUTE: if (s_r.ws[0]) s_nxt.route = s_r.wd[7:0];
            `PCIE_SKT_PRESENT, `PCIE_FUNC_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
         endcase
         s_nxt.rsp.bresp = wr_hit ? `PCIE_RESP_OKAY : `PCIE_RESP_SLVERR;
      end
      if (s_r.rsp.bvalid && axi_req.bready) begin
         s_nxt.rsp.bvalid = 1'b0;
      end

      if (axi_req.arvalid && !s_r.rsp.rvalid && !s_r.rsp.arready) begin
         s_nxt.rsp.arready = 1'b1;
      end
      rd_go  = s_r.rsp.arready;
      rd_a   = axi_req.araddr[7:0];
      rd_d   = 32'h0;
      rd_hit = 1'b1;
      unique case (rd_a)
         `PCIE_SKT_EVENT:    rd_d = {28'h0, s_r.sk_flag};
         `PCIE_SKT_MASK:     rd_d = {28'h0, s_r.sk_mask};
         `PCIE_SKT_PRESENT:  rd_d = {26'h0, s_r.sync2[5:4], card.kind, s_r.sync2[0], 1'b0};
         `PCIE_SKT_FORCE:    rd_d = 32'h0;
         `PCIE_SKT_CONTROL:  rd_d = s_r.ctrl;
         `PCIE_SKT_PWR_MGMT: rd_d = s_r.pm;
         `PCIE_LEG_FLAGS:    rd_d = {28'h0, s_r.lg_flag};
         `PCIE_LEG_MASK:     rd_d = {28'h0, s_r.lg_mask};
         `PCIE_LEG_GLOBAL:   rd_d = {24'h0, s_r.glob};
         `PCIE_FUNC_STATUS:  rd_d = {31'h0, s_r.func};
         `PCIE_ROUTE:        rd_d = {24'h0, s_r.route};
         default:            rd_hit = 1'b0;
      endcase
      if (rd_go) begin
         s_nxt.rsp.rvalid = 1'b1;
         s_nxt.rsp.rdata  = rd_d;
         s_nxt.rsp.rresp  = rd_hit ? `PCIE_RESP_OKAY : `PCIE_RESP_SLVERR;
         if (rd_a == `PCIE_LEG_FLAGS && !s_r.glob[`PCIE_BIT_CLR_W1C]) begin
            lg_clr = lg_clr | s_r.lg_flag;
         end
      end
      if (s_r.rsp.rvalid && axi_req.rready) begin
         s_nxt.rsp.rvalid = 1'b0;
      end

      // ----------------------------------------
      // Flags: set wins over clear
      // ----------------------------------------
      s_nxt.sk_flag = (s_r.sk_flag & ~sk_clr) | sk_set;
      s_nxt.lg_flag = (s_r.lg_flag & ~lg_clr) | lg_set;

      // ----------------------------------------
      // Interrupt generation and routing
      // ----------------------------------------
      // A set mask bit blocks its event; functional requests have no mask
      csc_req   = |(s_r.sk_flag & ~s_r.sk_mask) | |(s_r.lg_flag & ~s_r.lg_mask);
      func_req  = s_r.func;
      csc_pins  = one_hot8(s_r.route[2:0], csc_req);
      func_pins = one_hot8(s_r.route[6:4], func_req & s_r.route[7]);
      s_nxt.irq_pins  = csc_pins | func_pins;
      s_nxt.pci_int_n = ~(func_req | (csc_req & s_r.route[3]));
      s_nxt.ser_irq   = ~(|(csc_pins | func_pins));

      if (!rst_n) begin
         s_nxt = '0;
         s_nxt.sk_mask = `PCIE_MASK_RST;
         s_nxt.lg_mask = `PCIE_MASK_RST;
         s_nxt.glob    = `PCIE_GLOBAL_RST;
         s_nxt.route   = `PCIE_ROUTE_RST;
         s_nxt.pci_int_n = 1'b1;
         s_nxt.ser_irq   = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      s_r <= s_nxt;
   end

   // Every output is a flop of the state, no gates after it
   assign axi_rsp              = s_r.rsp;
   assign legacy_irq_route_pin = s_r.irq_pins;
   assign pci_int_n            = s_r.pci_int_n;
   assign serialized_irq_line  = s_r.ser_irq;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_MEM_NO_FUNC: assert property (is_mem |=> !s_r.func)
      else $error("functional request seen with memory card");
   AST_CD_EDGE: assert property (edg[5] |=> s_r.sk_flag[`PCIE_BIT_CD_A])
      else $error("card detect edge not flagged");
   AST_BVD_MEM: assert property (is_mem && edg[3] |=> s_r.lg_flag[1])
      else $error("battery edge not flagged");
   AST_READY_MEM: assert property (is_mem && edg[1] |=> s_r.lg_flag[2])
      else $error("ready edge not flagged");
   AST_FUNC_PASS: assert property (s_r.func |=> !pci_int_n)
      else $error("functional interrupt not forwarded");
   AST_MASKED: assert property ((s_r.sk_flag & ~s_r.sk_mask) == 4'h0 &&
                                (s_r.lg_flag & ~s_r.lg_mask) == 4'h0 && !s_r.func
                                |=> pci_int_n)
      else $error("masked event raised interrupt");
   AST_SK_STICKY: assert property (s_r.sk_flag[0] && !(wr_go &&
                                   s_r.awa == `PCIE_SKT_EVENT) |=> s_r.sk_flag[0])
      else $error("socket flag cleared without write-1");
   AST_RD_ANSWER: assert property (axi_req.arvalid && s_r.rsp.arready |=> s_r.rsp.rvalid)
      else $error("read not answered");
   AST_FORCE: assert property (wr_go && s_r.awa == `PCIE_SKT_FORCE && s_r.ws[0] && s_r.wd[3]
                               |=> s_r.sk_flag[3])
      else $error("force event not applied");

   // ----------------------------------------
   // Assertions: card events
   // ----------------------------------------
   AST_CD_B_EDGE: assert property (edg[4] |=> s_r.sk_flag[`PCIE_BIT_CD_B])
      else $error("second card detect edge not flagged");

   AST_BVD2_MEM: assert property (is_mem && edg[2] |=> s_r.lg_flag[`PCIE_BIT_BVD2])
      else $error("second battery edge not flagged");

   AST_IO_STSCHG: assert property (is_io && s_r.sync2[3] && !s_r.prev[3]
                                   |=> s_r.lg_flag[`PCIE_BIT_STSCHG])
      else $error("status change of I/O card not flagged");

   AST_CB_CSTS: assert property (is_cb && s_r.sync2[3] && !s_r.prev[3]
                                 |=> s_r.sk_flag[`PCIE_BIT_CSTS])
      else $error("status change of CardBus card not flagged");

   AST_IO_FUNC: assert property (is_io && s_r.sync2[0] |=> s_r.func)
      else $error("I/O card request not passed on");

   AST_CB_FUNC: assert property (is_cb && s_r.sync2[0] |=> s_r.func)
      else $error("CardBus card request not passed on");

   AST_PWR_CB: assert property (is_cb && pwr_evt |=> s_r.sk_flag[`PCIE_BIT_PWR])
      else $error("power-up done not flagged in socket event");

   AST_PWR_LEG: assert property ((is_mem || is_io) && pwr_evt
                                 |=> s_r.lg_flag[`PCIE_BIT_PWR])
      else $error("power-up done not flagged in legacy flags");

   // ----------------------------------------
   // Assertions: registers
   // ----------------------------------------
   AST_LEG_ROR: assert property (rd_go && rd_a == `PCIE_LEG_FLAGS
                                 && !s_r.glob[`PCIE_BIT_CLR_W1C] && lg_set == 4'h0
                                 |=> s_r.lg_flag == 4'h0)
      else $error("legacy flags kept after read");

   AST_LEG_W1C_KEEP: assert property (s_r.glob[`PCIE_BIT_CLR_W1C] && !wr_go
                                      && s_r.lg_flag[0] |=> s_r.lg_flag[0])
      else $error("legacy flag lost without write-1");

   AST_SK_ZERO_KEEP: assert property (wr_go && s_r.awa == `PCIE_SKT_EVENT
                                      && !s_r.wd[1] && s_r.sk_flag[1] |=> s_r.sk_flag[1])
      else $error("socket flag cleared by zero bit");

   AST_SK_W1C: assert property (wr_go && s_r.awa == `PCIE_SKT_EVENT && s_r.ws[0]
                                && s_r.wd[0] && !sk_set[0] |=> !s_r.sk_flag[0])
      else $error("socket flag kept after write-1");

   AST_FORCE_ZERO: assert property (wr_go && s_r.awa == `PCIE_SKT_FORCE && !s_r.wd[2]
                                    && !edg[4] && !s_r.sk_flag[2] |=> !s_r.sk_flag[2])
      else $error("force event set a zero bit");

   AST_MASK_WR: assert property (wr_go && s_r.awa == `PCIE_SKT_MASK && s_r.ws[0]
                                 |=> s_r.sk_mask == $past(s_r.wd[3:0]))
      else $error("socket mask not written");

   AST_RDATA_SK: assert property (rd_go && rd_a == `PCIE_SKT_EVENT
                                  |=> s_r.rsp.rdata == {28'h0, $past(s_r.sk_flag)})
      else $error("socket event read wrong");

   AST_RDATA_LG: assert property (rd_go && rd_a == `PCIE_LEG_FLAGS
                                  |=> s_r.rsp.rdata == {28'h0, $past(s_r.lg_flag)})
      else $error("legacy flags read wrong");

   AST_RDATA_FUNC: assert property (rd_go && rd_a == `PCIE_FUNC_STATUS
                                    |=> s_r.rsp.rdata == {31'h0, $past(s_r.func)})
      else $error("functional status read wrong");

   AST_RDATA_KIND: assert property (rd_go && rd_a == `PCIE_SKT_PRESENT
                                    |=> s_r.rsp.rdata[3:2] == $past(card.kind))
      else $error("card kind read wrong");

   AST_RD_PM: assert property (rd_go && rd_a == `PCIE_SKT_PWR_MGMT
                               |=> s_r.rsp.rresp == `PCIE_RESP_OKAY)
      else $error("power management read refused");

   AST_RD_RSV: assert property (rd_go && rd_a == `PCIE_SKT_RSV
                                |=> s_r.rsp.rresp == `PCIE_RESP_SLVERR)
      else $error("reserved read accepted");

   AST_WR_RSV: assert property (wr_go && s_r.awa == `PCIE_SKT_RSV
                                |=> s_r.rsp.bresp == `PCIE_RESP_SLVERR)
      else $error("reserved write accepted");

   // ----------------------------------------
   // Assertions: interrupt outputs
   // ----------------------------------------
   AST_ROUTE_CSC: assert property (csc_req && s_r.route[2:0] == 3'h3
                                   |=> legacy_irq_route_pin[3])
      else $error("status change not on its routed line");

   AST_ROUTE_FUNC: assert property (func_req && s_r.route[7] && s_r.route[6:4] == 3'h5
                                    |=> legacy_irq_route_pin[5])
      else $error("functional request not on its routed line");

   AST_SER_LOW: assert property (legacy_irq_route_pin != 8'h0 |-> !serialized_irq_line)
      else $error("serial line idle while a request is routed");

   AST_CSC_PCI: assert property (csc_req && s_r.route[3] |=> !pci_int_n)
      else $error("enabled status change not on PCI interrupt");

   // ----------------------------------------
   // Cover properties
   // ----------------------------------------
   COV_IRQ: cover property (!pci_int_n);
   COV_W1C: cover property (wr_go && s_r.awa == `PCIE_SKT_EVENT);
   COV_ROR: cover property (rd_go && rd_a == `PCIE_LEG_FLAGS);
   COV_FUNC_LINE: cover property (legacy_irq_route_pin[5]);
   COV_FORCE: cover property (wr_go && s_r.awa == `PCIE_SKT_FORCE);
endmodule // pcie_events

// ==== verification/pcie_card_model.sv ====
module pcie_card_model (
   input  wire logic                 clk,
   output pcie_pkg::pcie_card_pins_t card
);
   timeunit 1ns;
   timeprecision 1ps;
   import pcie_pkg::*;
   // ------------------------------------
   // Socket pins, one edge per call; the irq pin (bit 3) is left alone until pwr_done (bit 2) has toggled
   // ------------------------------------
   logic powered = 1'b0;
   initial card = '0;
   task automatic toggle(input int i);
      @(posedge clk);
      if (i == 3 && !powered) return;
      card[i] <= ~card[i];
      if (i == 2) powered = 1'b1;
   endtask
   task automatic set_kind(input pcie_card_t k);
      @(posedge clk);
      card.kind <= k;
   endtask
endmodule // pcie_card_model

// ==== verification/pcie_events_tb.sv ====
module pcie_events_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pcie_pkg::*;
   localparam int CD1 = 8, CD2 = 7, BVD1 = 6, BVD2 = 5, RDY = 4, IRQ = 3, PWR = 2;
   logic            clk = 1'b0;
   logic            rst_n = 1'b0;
   pcie_card_pins_t card;
   pcie_axi_req_t   req = '0;
   pcie_axi_rsp_t   rsp;
   logic [7:0]      route_pin;
   logic            pci_int_n;
   logic            ser_irq;
   logic [31:0]     rd_d;
   logic [1:0]      resp;
   int              failures = 0;
   int              n_checks = 0;
   always #5 clk = ~clk;
   pcie_events u_dut (.clk(clk), .rst_n(rst_n), .card(card), .axi_req(req), .axi_rsp(rsp),
      .legacy_irq_route_pin(route_pin), .pci_int_n(pci_int_n), .serialized_irq_line(ser_irq));
   pcie_card_model u_card (.clk(clk), .card(card));
   // ------------------------------------
   // Bus and compare helpers
   // ------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req.awaddr <= {24'h00, a};
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid && n < 100);
      if (!rsp.bvalid) failures++;
      resp = rsp.bresp;
      req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk);
      req.araddr <= {24'h00, a};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid && n < 100);
      if (!rsp.rvalid) failures++;
      rd_d = rsp.rdata;
      resp = rsp.rresp;
      req.rready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rd_d, e);
   endtask
   task automatic pins(input int i);
      u_card.toggle(i);
      repeat (5) @(posedge clk);
   endtask
   // ------------------------------------
   // Scenarios
   // ------------------------------------
   task automatic t_reset();
      chk(32'(pci_int_n), 32'h1);
      chk(32'(ser_irq), 32'h1);
      rc(8'h04, 32'hf);
      rd(8'h14);
      chk(32'(resp), 32'h2);
      rd(8'h20);
      chk(32'(resp), 32'h0);
      wr(8'h14, 32'h0);
      chk(32'(resp), 32'h2);
   endtask
   task automatic t_mem();
      wr(8'h44, 32'h0);
      chk(32'(resp), 32'h0);
      pins(PWR);
      rc(8'h40, 32'h8);
      rc(8'h40, 32'h0);
      pins(IRQ);
      rc(8'h4c, 32'h0);
      pins(IRQ);
      pins(RDY);
      rc(8'h40, 32'h4);
      pins(BVD1);
      pins(BVD2);
      rc(8'h40, 32'h3);
      wr(8'h48, 32'h4);
      pins(RDY);
      rc(8'h40, 32'h4);
      rc(8'h40, 32'h4);
      wr(8'h40, 32'h4);
      rc(8'h40, 32'h0);
   endtask
   task automatic t_cbus();
      // Socket status and power bits set only while the CardBus card runs; card detect bits for any kind
      u_card.set_kind(PCIE_CARD_CBUS);
      repeat (5) @(posedge clk);
      rc(8'h08, 32'h8);
      pins(PWR);
      pins(PWR);
      rc(8'h00, 32'h8);
      wr(8'h04, 32'h0);
      wr(8'h50, 32'h0b);
      repeat (3) @(posedge clk);
      chk(32'(pci_int_n), 32'h0);
      chk(32'(route_pin), 32'h08);
      chk(32'(ser_irq), 32'h0);
      wr(8'h00, 32'h8);
      repeat (3) @(posedge clk);
      chk(32'(pci_int_n), 32'h1);
      pins(CD1);
      rc(8'h00, 32'h2);
      wr(8'h00, 32'h0);
      rc(8'h00, 32'h2);
      wr(8'h00, 32'h2);
      rc(8'h00, 32'h0);
      wr(8'h0c, 32'h5);
      rc(8'h00, 32'h5);
      wr(8'h00, 32'h5);
      pins(BVD1);
      pins(BVD1);
      rc(8'h00, 32'h1);
      wr(8'h00, 32'h1);
      wr(8'h04, 32'hf);
      pins(CD2);
      rc(8'h00, 32'h4);
      chk(32'(pci_int_n), 32'h1);
      wr(8'h00, 32'h4);
      pins(IRQ);
      rc(8'h4c, 32'h1);
      chk(32'(pci_int_n), 32'h0);
      wr(8'h50, 32'hd0);
      repeat (3) @(posedge clk);
      chk(32'(route_pin), 32'h20);
      chk(32'(ser_irq), 32'h0);
      pins(IRQ);
   endtask
   task automatic t_io();
      u_card.set_kind(PCIE_CARD_IO16);
      repeat (5) @(posedge clk);
      wr(8'h40, 32'hf);
      pins(BVD1);
      pins(BVD1);
      rc(8'h40, 32'h1);
      pins(IRQ);
      rc(8'h4c, 32'h1);
   endtask
   // ------------------------------------
   // Run control
   // ------------------------------------
   task automatic end_of_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_mem();
      t_cbus();
      t_io();
      end_of_test();
   end
endmodule // pcie_events_tb
